/* src/mbs_defs.svh */
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH

// ==========================================================================
// apb register byte addresses
`define MBS_APB_CTRL 8'h00
`define MBS_APB_FLAGS 8'h04
`define MBS_APB_EVENT 8'h08
`define MBS_APB_INT_STATUS 8'h0C
`define MBS_APB_INT_MASK 8'h10
`define MBS_APB_PORT_STATUS 8'h14

// ==========================================================================
// host port byte addresses
`define MBS_HOST_CTRL 8'h0B
`define MBS_HOST_FLAGS 8'h0C
`define MBS_HOST_RAM_BASE 8'h0E
`define MBS_RAM_DEPTH 8
`define MBS_RAM_IDX_W 3

// ==========================================================================
// host byte field positions
`define MBS_HB_PERIODIC_IE 6
`define MBS_HB_ALARM_IE 5
`define MBS_HB_UPDATE_IE 4
`define MBS_HB_SQUARE_EN 3
`define MBS_HB_IRQ_SUMMARY 7
`define MBS_HB_PERIODIC_FLAG 6
`define MBS_HB_ALARM_FLAG 5
`define MBS_HB_UPDATE_FLAG 4

// ==========================================================================
// apb field positions: event register and interrupt status
`define MBS_EV_PERIODIC 0
`define MBS_EV_ALARM 1
`define MBS_EV_UPDATE 2
`define MBS_IS_HOST_WRITE 0
`define MBS_IS_HOST_READ 1
`define MBS_IS_HOST_RESET 2
`define MBS_IS_NO_SELECT 3
`define MBS_IS_W 4

// ==========================================================================
// reset values
`define MBS_CTRL_RESET 4'h0
`define MBS_FLAGS_RESET 4'h0
`define MBS_INT_RESET 4'h0
// pins at rest: write line, select and host reset high, so no false edge follows reset
`define MBS_PINS_IDLE 14'h0700

// ==========================================================================
// timing: least host reset hold at power-up, kept by the host
`define MBS_HOST_RESET_MIN_MS 200

`endif

/* src/mbs_pkg.sv */
package mbs_pkg;

    // ======================================================================
    // synchronised pin sample
    typedef struct packed {
        logic style;
        logic rstrobe;
        logic astrobe;
        logic wline;
        logic csel_n;
        logic hrst_n;
        logic [7:0] ad;
    } mbs_pins_t;

    typedef struct packed {
        logic periodic_irq_enable;
        logic alarm_irq_enable;
        logic update_end_irq_enable;
        logic square_wave_enable;
    } mbs_ctrl_t;

    typedef struct packed {
        logic irq_summary_flag;
        logic periodic_flag;
        logic alarm_flag;
        logic update_flag;
    } mbs_flags_t;

    typedef enum logic [3:0] {
        MBS_ST_IDLE = 4'h1,
        MBS_ST_ADDR = 4'h2,
        MBS_ST_READ = 4'h4,
        MBS_ST_BLOCK = 4'h8
    } mbs_state_t;

endpackage

/* src/mbs_sync.sv */
module mbs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    // ======================================================================
    // two flops; stage1 feeds only the second flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= IDLE;
            q <= IDLE;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule

/* src/mbs_port.sv */
// Design decisions made here: the register offsets and the APB interface to the registers.
`include "mbs_defs.svh"

module mbs_port
    import mbs_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host port pins
    input wire logic bus_style_select,
    input wire logic read_strobe,
    input wire logic address_latch_strobe,
    input wire logic write_line,
    input wire logic chip_select_n,
    input wire logic host_reset_n,
    input wire logic [7:0] ad_level,
    output logic [7:0] ad_drive,
    output logic ad_drive_en_n,
    // interrupt request pin, open drain
    output logic irq_pin_drive,
    output logic irq_pin_drive_en_n,
    // square-wave gate and block interrupt
    output logic square_wave_out_enable,
    output logic interrupt
);

    // ======================================================================
    // decode helpers
    function automatic logic is_ram(input logic [7:0] a);
        is_ram = (a >= `MBS_HOST_RAM_BASE) &&
                 (a < 8'(`MBS_HOST_RAM_BASE + `MBS_RAM_DEPTH));
    endfunction

    function automatic logic [`MBS_RAM_IDX_W-1:0] ram_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - `MBS_HOST_RAM_BASE;
        ram_idx = off[`MBS_RAM_IDX_W-1:0];
    endfunction

    // ======================================================================
    // pin synchronisation
    mbs_pins_t pins_raw;
    mbs_pins_t pin;
    mbs_pins_t pin_q;

    assign pins_raw = '{style: bus_style_select, rstrobe: read_strobe,
                        astrobe: address_latch_strobe, wline: write_line,
                        csel_n: chip_select_n, hrst_n: host_reset_n, ad: ad_level};

    mbs_sync #(
        .WIDTH($bits(mbs_pins_t)),
        .IDLE(`MBS_PINS_IDLE)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pins_raw),
        .q(pin)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= `MBS_PINS_IDLE;
        end else begin
            pin_q <= pin;
        end
    end

    // ======================================================================
    // edge detection on synchronised strobes
    logic host_rst;
    logic style_pulse;
    logic rs_rise;
    logic rs_fall;
    logic as_rise;
    logic as_fall;
    logic wl_rise;
    logic read_start;
    logic read_end;
    logic write_edge;

    assign host_rst = ~pin.hrst_n;
    assign style_pulse = pin.style;
    assign rs_rise = pin.rstrobe & ~pin_q.rstrobe;
    assign rs_fall = ~pin.rstrobe & pin_q.rstrobe;
    assign as_rise = pin.astrobe & ~pin_q.astrobe;
    assign as_fall = ~pin.astrobe & pin_q.astrobe;
    assign wl_rise = pin.wline & ~pin_q.wline;
    // pulse style: read while strobe high, otherwise while strobe low
    assign read_start = style_pulse ? (rs_rise & pin.wline) : (rs_fall & pin.wline);
    assign read_end = style_pulse ? rs_fall : rs_rise;
    assign write_edge = style_pulse ? (rs_fall & ~pin.wline) : wl_rise;

    // ======================================================================
    // address latch
    logic [7:0] addr;
    logic addr_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr <= 8'h00;
            addr_sel <= 1'b0;
        end else if (as_fall) begin
            addr <= pin.ad;
            addr_sel <= ~pin.csel_n;
        end
    end

    // ======================================================================
    // host cycle state
    mbs_state_t state;
    logic acc_ok;
    logic host_wr;
    logic host_rd;
    logic no_select;

    // select must be held through the strobe as well as at the address
    assign acc_ok = addr_sel & ~pin.csel_n;
    assign host_wr = (state == MBS_ST_ADDR) & write_edge & acc_ok & ~host_rst;
    assign host_rd = (state == MBS_ST_ADDR) & read_start & acc_ok & ~host_rst & ~as_rise;
    assign no_select = (state == MBS_ST_ADDR) & (read_start | write_edge) & ~acc_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MBS_ST_BLOCK;
        end else if (host_rst) begin
            state <= MBS_ST_BLOCK;
        end else begin
            case (state)
                MBS_ST_BLOCK: begin
                    state <= MBS_ST_IDLE;
                end
                MBS_ST_IDLE: begin
                    if (as_fall) begin
                        state <= MBS_ST_ADDR;
                    end
                end
                MBS_ST_ADDR: begin
                    // a fresh address strobe discards the latched address
                    if (as_rise) begin
                        state <= MBS_ST_IDLE;
                    end else if (host_rd) begin
                        state <= MBS_ST_READ;
                    end else if (write_edge | read_start) begin
                        state <= MBS_ST_IDLE;
                    end
                end
                MBS_ST_READ: begin
                    if (read_end || as_rise) begin
                        state <= MBS_ST_IDLE;
                    end
                end
                default: begin
                    state <= MBS_ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // control bits
    mbs_ctrl_t ctrl;
    logic apb_wr;
    logic apb_access;

    assign apb_access = psel & penable & ~pready;
    assign apb_wr = psel & penable & pready & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `MBS_CTRL_RESET;
        end else if (host_rst) begin
            ctrl <= `MBS_CTRL_RESET;
        end else if (host_wr && addr == `MBS_HOST_CTRL) begin
            ctrl.periodic_irq_enable <= pin.ad[`MBS_HB_PERIODIC_IE];
            ctrl.alarm_irq_enable <= pin.ad[`MBS_HB_ALARM_IE];
            ctrl.update_end_irq_enable <= pin.ad[`MBS_HB_UPDATE_IE];
            ctrl.square_wave_enable <= pin.ad[`MBS_HB_SQUARE_EN];
        end else if (apb_wr && paddr == `MBS_APB_CTRL) begin
            ctrl <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            square_wave_out_enable <= 1'b0;
        end else begin
            square_wave_out_enable <= ctrl.square_wave_enable & ~host_rst;
        end
    end

    // ======================================================================
    // interrupt flags: set by core events, cleared by a host read of them
    mbs_flags_t flags;
    logic ev_periodic;
    logic ev_alarm;
    logic ev_update;
    logic flags_clr;
    logic next_summary;

    assign ev_periodic = apb_wr && paddr == `MBS_APB_EVENT && pwdata[`MBS_EV_PERIODIC];
    assign ev_alarm = apb_wr && paddr == `MBS_APB_EVENT && pwdata[`MBS_EV_ALARM];
    assign ev_update = apb_wr && paddr == `MBS_APB_EVENT && pwdata[`MBS_EV_UPDATE];
    assign flags_clr = host_rd && addr == `MBS_HOST_FLAGS;
    assign next_summary = (flags.periodic_flag & ctrl.periodic_irq_enable)
                        | (flags.alarm_flag & ctrl.alarm_irq_enable)
                        | (flags.update_flag & ctrl.update_end_irq_enable);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= `MBS_FLAGS_RESET;
        end else if (host_rst) begin
            flags <= `MBS_FLAGS_RESET;
        end else begin
            // an event landing with the clearing read survives it
            flags.periodic_flag <= ev_periodic | (flags.periodic_flag & ~flags_clr);
            flags.alarm_flag <= ev_alarm | (flags.alarm_flag & ~flags_clr);
            flags.update_flag <= ev_update | (flags.update_flag & ~flags_clr);
            flags.irq_summary_flag <= next_summary & ~flags_clr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pin_drive <= 1'b0;
            irq_pin_drive_en_n <= 1'b1;
        end else begin
            irq_pin_drive <= 1'b0;
            irq_pin_drive_en_n <= host_rst | ~flags.irq_summary_flag;
        end
    end

    // ======================================================================
    // byte storage; host reset does not reach it
    logic [7:0] ram [`MBS_RAM_DEPTH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `MBS_RAM_DEPTH; i++) begin
                ram[i] <= 8'h00;
            end
        end else if (host_wr && is_ram(addr)) begin
            ram[ram_idx(addr)] <= pin.ad;
        end
    end

    // ======================================================================
    // host read data and bus drive
    logic [7:0] host_byte;

    always_comb begin
        host_byte = 8'h00;
        if (addr == `MBS_HOST_CTRL) begin
            host_byte[`MBS_HB_PERIODIC_IE] = ctrl.periodic_irq_enable;
            host_byte[`MBS_HB_ALARM_IE] = ctrl.alarm_irq_enable;
            host_byte[`MBS_HB_UPDATE_IE] = ctrl.update_end_irq_enable;
            host_byte[`MBS_HB_SQUARE_EN] = ctrl.square_wave_enable;
        end else if (addr == `MBS_HOST_FLAGS) begin
            host_byte[`MBS_HB_IRQ_SUMMARY] = flags.irq_summary_flag;
            host_byte[`MBS_HB_PERIODIC_FLAG] = flags.periodic_flag;
            host_byte[`MBS_HB_ALARM_FLAG] = flags.alarm_flag;
            host_byte[`MBS_HB_UPDATE_FLAG] = flags.update_flag;
        end else if (is_ram(addr)) begin
            host_byte = ram[ram_idx(addr)];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ad_drive <= 8'h00;
            ad_drive_en_n <= 1'b1;
        end else if (host_rst) begin
            ad_drive_en_n <= 1'b1;
        end else if (host_rd) begin
            ad_drive <= host_byte;
            ad_drive_en_n <= 1'b0;
        end else if (state == MBS_ST_READ && (read_end || as_rise)) begin
            ad_drive_en_n <= 1'b1;
        end
    end

    // ======================================================================
    // block interrupt: sticky status, write one to clear
    logic [`MBS_IS_W-1:0] int_status;
    logic [`MBS_IS_W-1:0] int_mask;
    logic [`MBS_IS_W-1:0] int_events;
    logic [`MBS_IS_W-1:0] int_clr;
    logic host_rst_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_rst_q <= 1'b0;
        end else begin
            host_rst_q <= host_rst;
        end
    end

    always_comb begin
        int_events = `MBS_INT_RESET;
        int_events[`MBS_IS_HOST_WRITE] = host_wr;
        int_events[`MBS_IS_HOST_READ] = host_rd;
        int_events[`MBS_IS_HOST_RESET] = host_rst & ~host_rst_q;
        int_events[`MBS_IS_NO_SELECT] = no_select;
        int_clr = (apb_wr && paddr == `MBS_APB_INT_STATUS) ? pwdata[`MBS_IS_W-1:0]
                                                          : `MBS_INT_RESET;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= `MBS_INT_RESET;
        end else begin
            int_status <= int_events | (int_status & ~int_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= `MBS_INT_RESET;
        end else if (apb_wr && paddr == `MBS_APB_INT_MASK) begin
            int_mask <= pwdata[`MBS_IS_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt <= 1'b0;
        end else begin
            interrupt <= |(int_status & int_mask);
        end
    end

    // ======================================================================
    // apb slave: pready one cycle after access starts
    logic [31:0] apb_rd;
    logic apb_hit;

    always_comb begin
        apb_rd = 32'h0000_0000;
        apb_hit = 1'b1;
        case (paddr)
            `MBS_APB_CTRL: apb_rd[3:0] = ctrl;
            `MBS_APB_FLAGS: apb_rd[3:0] = flags;
            `MBS_APB_EVENT: apb_rd = 32'h0000_0000;
            `MBS_APB_INT_STATUS: apb_rd[`MBS_IS_W-1:0] = int_status;
            `MBS_APB_INT_MASK: apb_rd[`MBS_IS_W-1:0] = int_mask;
            `MBS_APB_PORT_STATUS: apb_rd[16:0] = {style_pulse, host_rst, addr_sel,
                                                  state, addr, ad_drive_en_n,
                                                  irq_pin_drive_en_n};
            default: apb_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access & ~apb_hit;
            prdata <= (apb_access && !pwrite) ? apb_rd : 32'h0000_0000;
        end
    end

endmodule

/* bench/mbs_port_asserts.sv */
module mbs_port_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // host pins
    input wire logic bus_style_select,
    input wire logic read_strobe,
    input wire logic address_latch_strobe,
    input wire logic write_line,
    input wire logic host_reset_n,
    // device side
    input wire logic ad_drive_en_n,
    input wire logic irq_pin_drive,
    input wire logic irq_pin_drive_en_n,
    input wire logic square_wave_out_enable
);
    // ======================================================================
    // pin checks: six samples cover the synchroniser, edge detect and output flop
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rst_irq; (!host_reset_n) [*6] |-> irq_pin_drive_en_n; endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("irq pulled in host reset");
    property p_irq_low; irq_pin_drive == 1'b0; endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq pin driven high");
    property p_rst_sqw; (!host_reset_n) [*6] |-> !square_wave_out_enable; endproperty
    a_rst_sqw: assert property (p_rst_sqw) else $error("square wave on in reset");
    property p_rst_bus; (!host_reset_n) [*6] |-> ad_drive_en_n; endproperty
    a_rst_bus: assert property (p_rst_bus) else $error("bus driven in reset");
    property p_pulse_off; (bus_style_select && !read_strobe) [*6] |-> ad_drive_en_n; endproperty
    a_pulse_off: assert property (p_pulse_off) else $error("drive without strobe");
    property p_oe_off; (!bus_style_select && read_strobe) [*6] |-> ad_drive_en_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive without enable");
    property p_wr_off; (!write_line) [*6] |-> ad_drive_en_n; endproperty
    a_wr_off: assert property (p_wr_off) else $error("drive in write cycle");
    property p_as_off; address_latch_strobe [*6] |-> ad_drive_en_n; endproperty
    a_as_off: assert property (p_as_off) else $error("drive in address phase");
    property p_lat;
        $fell(ad_drive_en_n) |-> $past(read_strobe, 3) != $past(read_strobe, 4);
    endproperty
    a_lat: assert property (p_lat) else $error("drive start not three edges after strobe");
endmodule

bind mbs_port mbs_port_asserts chk (.pclk, .presetn, .bus_style_select, .read_strobe,
    .address_latch_strobe, .write_line, .host_reset_n, .ad_drive_en_n, .irq_pin_drive,
    .irq_pin_drive_en_n, .square_wave_out_enable);

/* bench/mbs_host_model.sv */
module mbs_host_model (
    // clock
    input wire logic pclk,
    // device drive
    input wire logic [7:0] ad_drive,
    input wire logic ad_drive_en_n,
    // host pins
    output logic bus_style_select,
    output logic read_strobe,
    output logic address_latch_strobe,
    output logic write_line,
    output logic chip_select_n,
    output logic host_reset_n,
    output logic [7:0] ad_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] host_ad = 8'h00;
    logic host_en = 1'b0;
    logic [7:0] float_ad = 8'hA5;
    // no pull on the bus: a released bus shows the inverse of its last level
    always_ff @(posedge pclk) float_ad <= ~ad_level;
    assign ad_level = !ad_drive_en_n ? ad_drive : (host_en ? host_ad : float_ad);
    initial begin
        bus_style_select = 1'b1;
        read_strobe = 1'b0;
        address_latch_strobe = 1'b0;
        write_line = 1'b1;
        chip_select_n = 1'b1;
        host_reset_n = 1'b1; // high from power-up, so no long power-up hold
    end
    task automatic hold(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // ======================================================================
    // one bus cycle; every phase but the closing two-cycle gap is held at least three times the synchroniser depth
    task automatic cycle(input logic pulse, input logic sel, input logic wr,
                         input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge pclk);
        bus_style_select <= pulse;
        read_strobe <= !pulse;
        write_line <= 1'b1;
        chip_select_n <= !sel;
        address_latch_strobe <= 1'b1;
        host_ad <= a;
        host_en <= 1'b1;
        hold(6);
        address_latch_strobe <= 1'b0;
        hold(6);
        host_ad <= wd;
        host_en <= wr;
        if (pulse) begin
            write_line <= !wr;
            read_strobe <= 1'b1; // strobe late in the cycle
        end else if (wr) begin
            write_line <= 1'b0;
        end else begin
            read_strobe <= 1'b0;
        end
        hold(8);
        rd = ad_level;
        read_strobe <= !pulse;
        // pulse write: direction stays low past the strobe's trailing edge
        if (!pulse) begin
            write_line <= 1'b1;
        end
        hold(6);
        write_line <= 1'b1;
        host_en <= 1'b0;
        chip_select_n <= 1'b1;
        hold(2);
    endtask
    task automatic set_rst(input logic v);
        @(posedge pclk);
        host_reset_n <= v;
        hold(8);
    endtask
endmodule

/* bench/mux_bus_strobe_and_reset_test.sv */
`include "mbs_defs.svh"

module mux_bus_strobe_and_reset_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, interrupt;
    logic bus_style_select, read_strobe, address_latch_strobe, write_line;
    logic chip_select_n, host_reset_n, ad_drive_en_n, irq_pin_drive;
    logic irq_pin_drive_en_n, square_wave_out_enable;
    logic [7:0] ad_level, ad_drive, hb;
    logic [31:0] rv;
    logic err;
    int n_fail = 0;
    int cmp_count = 0;
    int ram[8];
    mbs_port dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .bus_style_select, .read_strobe, .address_latch_strobe, .write_line,
        .chip_select_n, .host_reset_n, .ad_level, .ad_drive, .ad_drive_en_n, .irq_pin_drive,
        .irq_pin_drive_en_n, .square_wave_out_enable, .interrupt);
    mbs_host_model h (.pclk, .ad_drive, .ad_drive_en_n, .bus_style_select, .read_strobe,
        .address_latch_strobe, .write_line, .chip_select_n, .host_reset_n, .ad_level);
    initial forever #5 pclk = ~pclk;
    // ======================================================================
    // checking and apb master
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask
    // ======================================================================
    // main sequence
    initial begin
        int s, i, idx;
        logic [7:0] d;
        void'($urandom(32'h1a3bfb12));
        for (i = 0; i < 8; i++) ram[i] = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        rd_chk(`MBS_APB_CTRL, 32'h0);
        rd_chk(`MBS_APB_FLAGS, 32'h0);
        rd_chk(8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (s = 0; s < 2; s++) begin
            for (i = 0; i < 4; i++) begin
                idx = $urandom % 8;
                d = 8'($urandom);
                ram[idx] = d;
                h.cycle(s[0], 1'b1, 1'b1, `MBS_HOST_RAM_BASE + 8'(idx), d, hb);
                h.cycle(s[0], 1'b1, 1'b0, `MBS_HOST_RAM_BASE + 8'(idx), 8'h00, hb);
                chk({24'h0, hb}, ram[idx]);
            end
            d = 8'($urandom) & 8'h78;
            h.cycle(s[0], 1'b1, 1'b1, `MBS_HOST_CTRL, d, hb);
            rd_chk(`MBS_APB_CTRL, 32'(d >> 3));
            chk({31'h0, square_wave_out_enable}, 32'(d[3]));
        end
        // unselected write must latch the address yet leave the byte alone
        apb(1'b1, `MBS_APB_INT_STATUS, 32'hF);
        h.cycle(1'b1, 1'b0, 1'b1, `MBS_HOST_RAM_BASE, ~8'(ram[0]), hb);
        h.cycle(1'b1, 1'b1, 1'b0, `MBS_HOST_RAM_BASE, 8'h00, hb);
        chk({24'h0, hb}, ram[0]);
        rd_chk(`MBS_APB_INT_STATUS, 32'hA);
        apb(1'b1, `MBS_APB_INT_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, interrupt}, 32'h1);
        apb(1'b1, `MBS_APB_INT_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, interrupt}, 32'h0);
        apb(1'b1, `MBS_APB_INT_MASK, 32'h2);
        apb(1'b1, `MBS_APB_INT_STATUS, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, interrupt}, 32'h0);
        rd_chk(`MBS_APB_INT_STATUS, 32'h8);
        // flags, then host reset with the summary flag up
        h.cycle(1'b1, 1'b1, 1'b1, `MBS_HOST_CTRL, 8'h70, hb);
        apb(1'b1, `MBS_APB_EVENT, 32'h7);
        repeat (4) @(posedge pclk);
        rd_chk(`MBS_APB_FLAGS, 32'hF);
        h.cycle(1'b0, 1'b1, 1'b0, `MBS_HOST_FLAGS, 8'h00, hb);
        chk({24'h0, hb}, 32'hF0);
        rd_chk(`MBS_APB_FLAGS, 32'h0);
        apb(1'b1, `MBS_APB_EVENT, 32'h3);
        apb(1'b1, `MBS_APB_CTRL, 32'hF);
        apb(1'b1, `MBS_APB_INT_STATUS, 32'hF);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq_pin_drive_en_n}, 32'h0);
        h.set_rst(1'b0);
        chk({31'h0, irq_pin_drive_en_n}, 32'h1);
        chk({31'h0, square_wave_out_enable}, 32'h0);
        rd_chk(`MBS_APB_CTRL, 32'h0);
        rd_chk(`MBS_APB_FLAGS, 32'h0);
        h.cycle(1'b1, 1'b1, 1'b0, `MBS_HOST_RAM_BASE, 8'h00, hb);
        h.set_rst(1'b1);
        rd_chk(`MBS_APB_INT_STATUS, 32'h4);
        for (i = 0; i < 8; i++) begin
            h.cycle(1'b1, 1'b1, 1'b0, `MBS_HOST_RAM_BASE + 8'(i), 8'h00, hb);
            chk({24'h0, hb}, ram[i]);
        end
        // pulse style, selected, idle, last address 0x15, bus and irq released
        rd_chk(`MBS_APB_PORT_STATUS, 32'h0001_4457);
        report_and_stop();
    end
endmodule
